// ---- conv_control.sv ----
// Behaviour
// - reading the low result byte freezes both bytes until the high byte is read.
// - each finished conversion loads its ten-bit result into the result byte pair while the pair is not frozen.
// - left alignment puts bits 9:2 in high byte, bits 1:0 at low 7:6.
// - right alignment, the reset default, puts bits 7:0 low and 9:8 high.
// - bipolar mode gives two's complement results, nine magnitude bits plus sign.
// - unipolar mode gives ten bits, full scale when negative is not below positive.
// - polarity reversal swaps the differential pair in unipolar mode.
// - control register b bits 4 and 3 always read zero.
// - trigger source field only acts while auto trigger is enabled.
// - a rising edge of the selected trigger flag starts a conversion.
// - switching from a clear source to a set source counts as rising edge.
// - switching to free running never triggers by itself.
// - trigger codes: free run, comparator, int0, cmpA, overflow, cmpB, pin change.
// - a set pin disable bit turns off that pin input, which reads zero.
// - alignment changes show on the result bytes at once.
// - auto trigger enable lets the selected trigger start conversions.
// - completion flag sets on each finished conversion; writing one clears it.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"

module conv_control (
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // converter front end
   input  wire logic                       conv_done,
   input  wire logic [9:0]                 conv_pos,
   input  wire logic [9:0]                 conv_neg,
   output logic                            conv_start,
   output logic                            conv_active,
   output conv_pkg::conv_cfg_s             conv_cfg,
   // trigger flags of other peripherals
   input  wire conv_pkg::trigger_flags_s   trig_flags,
   // analog pins digital path
   input  wire logic [3:0]                 analog_pin_in,
   output logic      [3:0]                 pin_input_off,
   output logic      [3:0]                 pin_read_value
);

   conv_pkg::ctrl_state_s s_reg;
   conv_pkg::ctrl_state_s s_next;

   logic [9:0]           formed;
   logic [3:0]           pin_value;
   logic                 access;
   logic                 capture;
   logic                 complete;
   logic [5:0]           idx;
   logic                 mapped;
   logic [7:0]           rd_byte;
   logic [7:0]           low_byte;
   logic [7:0]           high_byte;
   logic                 busy;
   logic                 enabled;
   logic                 sel_level;
   logic                 trig_edge;
   conv_pkg::trig_src_e  trig_src;

   result_former u_former (
      .bipolar  (s_reg.ctrl_b[`CB_BIPOLAR_BIT]),
      .reverse  (s_reg.ctrl_b[`CB_REVERSE_BIT]),
      .pos_code (conv_pos),
      .neg_code (conv_neg),
      .result   (formed)
   );

   pin_input_gate u_pins (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .pin_raw      (analog_pin_in),
      .disable_bits (s_reg.pin_dis[`PD_MSB:`PD_LSB]),
      .pin_value    (pin_value)
   );

   // result presentation follows the live alignment bit
   always_comb begin
      if (s_reg.in_sel[`IS_ALIGN_BIT]) begin
         high_byte = s_reg.result[9:2];
         low_byte  = {s_reg.result[1:0], 6'h00};
      end else begin
         high_byte = {6'h00, s_reg.result[9:8]};
         low_byte  = s_reg.result[7:0];
      end
   end

   // selected trigger level
   always_comb begin
      trig_src = conv_pkg::trig_src_e'(s_reg.ctrl_b[`CB_TRIG_MSB:0]);
      unique case (trig_src)
         conv_pkg::TRIG_FREE_RUN:   sel_level = s_reg.ctrl_a[`CA_FLAG_BIT];
         conv_pkg::TRIG_COMPARATOR: sel_level = trig_flags.comparator;
         conv_pkg::TRIG_EXT_INT0:   sel_level = trig_flags.ext_int0;
         conv_pkg::TRIG_T0_CMPA:    sel_level = trig_flags.t0_cmpa;
         conv_pkg::TRIG_T0_OVF:     sel_level = trig_flags.t0_ovf;
         conv_pkg::TRIG_T0_CMPB:    sel_level = trig_flags.t0_cmpb;
         conv_pkg::TRIG_PIN_CHANGE: sel_level = trig_flags.pin_change;
         conv_pkg::TRIG_NONE:       sel_level = 1'b0;
      endcase
   end

   // register read mux
   always_comb begin
      idx    = paddr[7:2];
      mapped = (paddr[1:0] == 2'h0);
      unique case (idx)
         `IDX_CTRL_B:       rd_byte = s_reg.ctrl_b & `CB_WRITE_MASK;
         `IDX_RESULT_LOW:   rd_byte = low_byte;
         `IDX_RESULT_HIGH:  rd_byte = high_byte;
         `IDX_CTRL_A:       rd_byte = s_reg.ctrl_a;
         `IDX_INPUT_SELECT: rd_byte = s_reg.in_sel;
         `IDX_PIN_DISABLE:  rd_byte = s_reg.pin_dis;
         `IDX_PIN_VALUE:    rd_byte = {4'h0, pin_value};
         default: begin
            rd_byte = `RST_BYTE;
            mapped  = 1'b0;
         end
      endcase
   end

   always_comb begin
      s_next       = s_reg;
      s_next.start = 1'b0;

      access   = psel & penable;
      capture  = access & ~s_reg.pready;
      complete = access & s_reg.pready;
      busy     = s_reg.ctrl_a[`CA_START_BIT];
      enabled  = s_reg.ctrl_a[`CA_ENABLE_BIT];

      // first access cycle: sample read data, apply read effects
      if (capture) begin
         s_next.pready  = 1'b1;
         s_next.prdata  = {24'h000000, rd_byte};
         s_next.pslverr = ~mapped;
         if (!pwrite && mapped && idx == `IDX_RESULT_LOW) begin
            s_next.lock = 1'b1;
         end
         if (!pwrite && mapped && idx == `IDX_RESULT_HIGH) begin
            s_next.lock = 1'b0;
         end
      end

      // second access cycle: transfer ends, writes take effect
      if (complete) begin
         s_next.pready  = 1'b0;
         s_next.pslverr = 1'b0;
         if (pwrite && mapped) begin
            unique case (idx)
               `IDX_CTRL_A: begin
                  s_next.ctrl_a[`CA_ENABLE_BIT] = pwdata[`CA_ENABLE_BIT];
                  s_next.ctrl_a[`CA_AUTO_BIT]   = pwdata[`CA_AUTO_BIT];
                  s_next.ctrl_a[`CA_IE_BIT]     = pwdata[`CA_IE_BIT];
                  s_next.ctrl_a[`CA_PRESCALE_MSB:0] = pwdata[`CA_PRESCALE_MSB:0];
                  if (pwdata[`CA_FLAG_BIT]) begin
                     s_next.ctrl_a[`CA_FLAG_BIT] = 1'b0;
                  end
                  // start written together with enable is honoured
                  if (pwdata[`CA_START_BIT] && pwdata[`CA_ENABLE_BIT] && !busy) begin
                     s_next.start                 = 1'b1;
                     s_next.ctrl_a[`CA_START_BIT] = 1'b1;
                  end
               end
               `IDX_CTRL_B: begin
                  s_next.ctrl_b = pwdata[7:0] & `CB_WRITE_MASK;
               end
               `IDX_INPUT_SELECT: begin
                  s_next.in_sel = pwdata[7:0];
               end
               `IDX_PIN_DISABLE: begin
                  s_next.pin_dis = pwdata[7:0] & `PD_WRITE_MASK;
               end
               default: begin
                  s_next.pslverr = 1'b0;
               end
            endcase
         end
      end

      // trigger edge detection on the selected flag
      s_next.trig_level    = sel_level;
      s_next.trig_src_prev = s_reg.ctrl_b[`CB_TRIG_MSB:0];
      trig_edge = sel_level & ~s_reg.trig_level;
      if (trig_src == conv_pkg::TRIG_FREE_RUN &&
          s_reg.trig_src_prev != s_reg.ctrl_b[`CB_TRIG_MSB:0]) begin
         trig_edge = 1'b0;
      end
      if (s_reg.ctrl_a[`CA_AUTO_BIT] && trig_edge && enabled && !busy) begin
         s_next.start                 = 1'b1;
         s_next.ctrl_a[`CA_START_BIT] = 1'b1;
      end

      // conversion finished
      if (conv_done && busy) begin
         s_next.ctrl_a[`CA_START_BIT] = 1'b0;
         s_next.ctrl_a[`CA_FLAG_BIT]  = 1'b1;
         if (!s_reg.lock) begin
            s_next.result = formed;
         end
      end

      // disabling the converter aborts a conversion
      if (!s_next.ctrl_a[`CA_ENABLE_BIT]) begin
         s_next.ctrl_a[`CA_START_BIT] = 1'b0;
         s_next.start                 = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata           = s_reg.prdata;
   assign pready           = s_reg.pready;
   assign pslverr          = s_reg.pslverr;
   assign conv_start       = s_reg.start;
   assign conv_active      = s_reg.ctrl_a[`CA_START_BIT];
   assign conv_cfg         = '{enable:   s_reg.ctrl_a[`CA_ENABLE_BIT],
                               bipolar:  s_reg.ctrl_b[`CB_BIPOLAR_BIT],
                               reverse:  s_reg.ctrl_b[`CB_REVERSE_BIT],
                               channel:  s_reg.in_sel[`IS_CHANNEL_MSB:0],
                               prescale: s_reg.ctrl_a[`CA_PRESCALE_MSB:0]};
   assign pin_input_off    = s_reg.pin_dis[`PD_MSB:`PD_LSB];
   assign pin_read_value   = pin_value;

endmodule : conv_control

`default_nettype wire

// ---- conv_defines.svh ----
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_CTRL_B        6'h03
`define IDX_RESULT_LOW    6'h04
`define IDX_RESULT_HIGH   6'h05
`define IDX_CTRL_A        6'h06
`define IDX_INPUT_SELECT  6'h07
`define IDX_PIN_DISABLE   6'h08
`define IDX_PIN_VALUE     6'h09

// converter_control_status_a fields
`define CA_ENABLE_BIT     7
`define CA_START_BIT      6
`define CA_AUTO_BIT       5
`define CA_FLAG_BIT       4
`define CA_IE_BIT         3
`define CA_PRESCALE_MSB   2

// converter_control_status_b fields
`define CB_BIPOLAR_BIT    7
`define CB_REVERSE_BIT    5
`define CB_TRIG_MSB       2
`define CB_WRITE_MASK     8'hE7

// input_select_register fields
`define IS_ALIGN_BIT      5
`define IS_CHANNEL_MSB    3

// analog_pin_input_disable fields
`define PD_LSB            2
`define PD_MSB            5
`define PD_WRITE_MASK     8'h3C

// reset values and unipolar full scale code
`define RST_BYTE          8'h00
`define RST_RESULT        10'h000
`define FULL_SCALE        10'h3FF

`endif

// ---- conv_pkg.sv ----
package conv_pkg;

   // auto trigger source selections
   typedef enum logic [2:0] {
      TRIG_FREE_RUN   = 3'h0,
      TRIG_COMPARATOR = 3'h1,
      TRIG_EXT_INT0   = 3'h2,
      TRIG_T0_CMPA    = 3'h3,
      TRIG_T0_OVF     = 3'h4,
      TRIG_T0_CMPB    = 3'h5,
      TRIG_PIN_CHANGE = 3'h6,
      TRIG_NONE       = 3'h7
   } trig_src_e;

   typedef struct packed {
      logic comparator;
      logic ext_int0;
      logic t0_cmpa;
      logic t0_ovf;
      logic t0_cmpb;
      logic pin_change;
   } trigger_flags_s;

   typedef struct packed {
      logic       enable;
      logic       bipolar;
      logic       reverse;
      logic [3:0] channel;
      logic [2:0] prescale;
   } conv_cfg_s;

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  in_sel;
      logic [7:0]  pin_dis;
      logic [9:0]  result;
      logic        lock;
      logic        trig_level;
      logic [2:0]  trig_src_prev;
      logic        start;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ctrl_state_s;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] value;
   } pin_state_s;

endpackage : conv_pkg

// ---- result_former.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"

module result_former (
   // mode
   input  wire logic       bipolar,
   input  wire logic       reverse,
   // front end codes
   input  wire logic [9:0] pos_code,
   input  wire logic [9:0] neg_code,
   // formed result
   output logic      [9:0] result
);

   logic [9:0]  hi_in;
   logic [9:0]  lo_in;
   logic [10:0] diff;

   always_comb begin
      hi_in = reverse ? neg_code : pos_code;
      lo_in = reverse ? pos_code : neg_code;
      diff  = {1'b0, pos_code} - {1'b0, neg_code};
      if (bipolar) begin
         // sign plus nine magnitude bits, two's complement
         result = diff[10:1];
      end else if (lo_in >= hi_in) begin
         result = `FULL_SCALE;
      end else begin
         result = 10'(hi_in - lo_in);
      end
   end

endmodule : result_former

`default_nettype wire

// ---- pin_input_gate.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_input_gate (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // pins and control
   input  wire logic [3:0] pin_raw,
   input  wire logic [3:0] disable_bits,
   // gated value
   output logic      [3:0] pin_value
);

   conv_pkg::pin_state_s s_reg;
   conv_pkg::pin_state_s s_next;

   always_comb begin
      s_next       = s_reg;
      s_next.sync1 = pin_raw;
      s_next.sync2 = s_reg.sync1;
      s_next.value = s_reg.sync2 & ~disable_bits;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pin_value = s_reg.value;

endmodule : pin_input_gate

`default_nettype wire

// ---- conv_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module conv_checker (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     resetn,
   // apb
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [7:0]               paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   // converter and pins
   input wire logic                     conv_done,
   input wire logic                     conv_start,
   input wire logic                     conv_active,
   input wire conv_pkg::conv_cfg_s      conv_cfg,
   input wire conv_pkg::trigger_flags_s trig_flags,
   input wire logic [3:0]               pin_input_off,
   input wire logic [3:0]               pin_read_value
);
   logic       wr_done;
   logic       auto_reg;
   logic [2:0] src_reg;

   assign wr_done = psel && penable && pready && pwrite;

   // shadow of auto enable and trigger code
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         auto_reg <= 1'b0;
         src_reg  <= 3'h0;
      end else if (wr_done && paddr == 8'h18) begin
         auto_reg <= pwdata[5];
      end else if (wr_done && paddr == 8'h0C) begin
         src_reg <= pwdata[2:0];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_access;
      psel && penable && !pready;
   endsequence

   sequence s_comp_edge;
      auto_reg && conv_cfg.enable && !conv_active && !conv_start && !wr_done
         && src_reg == 3'h1 && $stable(src_reg) && $rose(trig_flags.comparator);
   endsequence

   a_wait_one: assert property (s_access |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access without error");
   a_reserved_zero: assert property (pready && !pwrite && paddr == 8'h0C |-> prdata[4:3] == 2'h0)
      else $error("reserved bits nonzero");
   a_done_idle: assert property (conv_active && conv_done |=> !conv_active)
      else $error("busy after done");
   a_start_busy: assert property (conv_start |-> conv_active)
      else $error("start without busy");
   a_edge_start: assert property (s_comp_edge |=> conv_start)
      else $error("no start on trigger edge");
   a_no_source: assert property ((!auto_reg || src_reg == 3'h7) && !$past(wr_done) |-> !conv_start)
      else $error("start without source");
   a_mode_bits: assert property (wr_done && paddr == 8'h0C |=>
      conv_cfg.bipolar == $past(pwdata[7]) && conv_cfg.reverse == $past(pwdata[5]))
      else $error("mode bits not applied");
   a_pin_gated: assert property ((pin_read_value & pin_input_off & $past(pin_input_off)
      & $past(pin_input_off, 2)) == 4'h0)
      else $error("disabled pin reads one");
   a_pin_off: assert property (wr_done && paddr == 8'h20 |=> pin_input_off == $past(pwdata[5:2]))
      else $error("pin disable not applied");
endmodule : conv_checker

bind conv_control conv_checker chk_u (
   .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_done(conv_done), .conv_start(conv_start), .conv_active(conv_active),
   .conv_cfg(conv_cfg), .trig_flags(trig_flags), .pin_input_off(pin_input_off),
   .pin_read_value(pin_read_value)
);

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic                     core_clk = 1'b0;
   logic                     resetn = 1'b0;
   logic                     psel = 1'b0;
   logic                     penable = 1'b0;
   logic                     pwrite = 1'b0;
   logic [7:0]               paddr = 8'h00;
   logic [31:0]              pwdata = 32'h0;
   logic                     conv_done = 1'b0;
   logic [9:0]               conv_pos = 10'h000;
   logic [9:0]               conv_neg = 10'h000;
   conv_pkg::trigger_flags_s trig_flags = 6'h00;
   logic [3:0]               pin_in = 4'h0;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic                     conv_start;
   logic [3:0]               pin_off;
   logic [3:0]               pin_val;
   logic                     active;
   conv_pkg::conv_cfg_s      cfg;
   logic [31:0]              rd;
   logic                     err;
   int                       fail_count = 0;
   int                       n_tests = 0;
   int                       cyc = 0;

   conv_control dut_u (
      .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_pos(conv_pos),
      .conv_neg(conv_neg), .conv_start(conv_start), .conv_active(active), .conv_cfg(cfg),
      .trig_flags(trig_flags), .analog_pin_in(pin_in), .pin_input_off(pin_off),
      .pin_read_value(pin_val)
   );

   always #12.5 core_clk = ~core_clk;

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one apb transfer, entered and left just after a rising edge
   task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // pready, prdata and pslverr taken as they stand at the rising edge
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb_xfer

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      apb_xfer(1'b1, a, d);
   endtask : wreg

   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb_xfer(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask : rchk

   task automatic finish_conv(input logic [9:0] p, input logic [9:0] n);
      conv_pos <= p;
      conv_neg <= n;
      conv_done <= 1'b1;
      @(posedge core_clk);
      conv_done <= 1'b0;
      @(posedge core_clk);
   endtask : finish_conv

   task automatic convert(input logic [9:0] p, input logic [9:0] n, input logic [9:0] exp);
      wreg(8'h18, 32'hC0);
      finish_conv(p, n);
      rchk("result low", 8'h10, {24'h0, exp[7:0]});
      rchk("result high", 8'h14, {30'h0, exp[9:8]});
   endtask : convert

   task automatic expect_start(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (6) begin
         @(negedge core_clk);
         seen = seen | conv_start;
      end
      @(posedge core_clk);
      check("conv start", {31'h0, seen}, {31'h0, exp});
      if (seen === 1'b1) begin
         finish_conv(10'h000, 10'h000);
         check("conv active", {31'h0, active}, 32'h0);
      end
   endtask : expect_start

   task automatic t_reset;
      logic [7:0] a [7] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
      foreach (a[i]) rchk("reset value", a[i], 32'h0);
      apb_xfer(1'b0, 8'h40, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb_xfer(1'b0, 8'h11, 32'h0);
      check("misaligned error", {31'h0, err}, 32'h1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_format;
      convert(10'h2D5, 10'h000, 10'h2D5);
      rchk("flag set", 8'h18, 32'h90);
      wreg(8'h18, 32'h90);
      rchk("flag cleared", 8'h18, 32'h80);
      wreg(8'h1C, 32'h20);
      rchk("left high", 8'h14, 32'hB5);
      rchk("left low", 8'h10, 32'h40);
      rchk("left high", 8'h14, 32'hB5);
      wreg(8'h1C, 32'h0);
      $display("format test done");
   endtask : t_format

   task automatic t_lock;
      convert(10'h155, 10'h000, 10'h155);
      rchk("locked low", 8'h10, 32'h55);
      wreg(8'h18, 32'hC0);
      finish_conv(10'h0AA, 10'h000);
      rchk("locked high", 8'h14, 32'h01);
      rchk("kept low", 8'h10, 32'h55);
      rchk("kept high", 8'h14, 32'h01);
      convert(10'h0AA, 10'h000, 10'h0AA);
      convert(10'h100, 10'h100, 10'h3FF);
      wreg(8'h0C, 32'h20);
      convert(10'h100, 10'h000, 10'h3FF);
      wreg(8'h0C, 32'h80);
      check("bipolar cfg", {31'h0, cfg.bipolar}, 32'h1);
      convert(10'h100, 10'h300, 10'h300);
      wreg(8'h0C, 32'h0);
      $display("lock and mode test done");
   endtask : t_lock

   task automatic t_trigger;
      wreg(8'h0C, 32'hFF);
      rchk("ctrl b mask", 8'h0C, 32'hE7);
      for (int c = 0; c < 8; c++) rchk_code(c[2:0]);
      wreg(8'h18, 32'hB0);
      for (int c = 1; c < 7; c++) begin
         wreg(8'h0C, c);
         trig_flags <= 6'h20 >> (c - 1);
         expect_start(1'b1);
         trig_flags <= 6'h00;
      end
      wreg(8'h0C, 32'h7);
      trig_flags <= 6'h3F;
      expect_start(1'b0);
      trig_flags <= 6'h00;
      wreg(8'h18, 32'h80);
      wreg(8'h0C, 32'h1);
      trig_flags <= 6'h20;
      expect_start(1'b0);
      trig_flags <= 6'h00;
      wreg(8'h18, 32'hA0);
      wreg(8'h0C, 32'h2);
      trig_flags <= 6'h20;
      expect_start(1'b0);
      wreg(8'h0C, 32'h1);
      expect_start(1'b1);
      // previous level low, completion flag high: only the suppression stops a start
      trig_flags <= 6'h00;
      wreg(8'h0C, 32'h0);
      expect_start(1'b0);
      // free running: a fresh completion flag restarts the converter
      wreg(8'h18, 32'hF0);
      finish_conv(10'h000, 10'h000);
      expect_start(1'b1);
      wreg(8'h18, 32'h90);
      trig_flags <= 6'h00;
      $display("trigger test done");
   endtask : t_trigger

   task automatic rchk_code(input logic [2:0] c);
      wreg(8'h0C, {29'h0, c});
      rchk("trigger code", 8'h0C, {29'h0, c});
   endtask : rchk_code

   task automatic t_pins;
      pin_in <= 4'hF;
      wreg(8'h20, 32'h14);
      rchk("pin value", 8'h24, 32'h0A);
      @(negedge core_clk);
      check("pin off", {28'h0, pin_off}, 32'h5);
      check("pin read", {28'h0, pin_val}, 32'hA);
      @(posedge core_clk);
      wreg(8'h20, 32'hFF);
      rchk("pin disable mask", 8'h20, 32'h3C);
      rchk("pin value off", 8'h24, 32'h0);
      $display("pin test done");
   endtask : t_pins

   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_format();
      t_lock();
      t_trigger();
      t_pins();
      stop_test();
   end
endmodule : tb

`default_nettype wire
